/* src/dtid_map.svh */
// Constants for the data-transfer instruction executor: behaviour list, addresses, codes, counts
// Behaviour
// - Eight byte registers X,A,C,B,E,D,L,H
// - Four register pairs AX,BC,DE,HL by index
// - Short direct addresses only FE20H to FF1FH
// - Absolute addresses 0000H-FFFFH, even for words
// - Table address: even addresses 0040H-007FH only
// - Immediates are 16, 8 and 3 bits
// - Byte accumulator A; word accumulator is A:X
// - Each flag kept, cleared, set, updated or restored
// - Immediate byte moves: 3 bytes, 6 clocks
// - Accumulator register/short/special moves: 2 bytes, 4 clocks
// - Accumulator absolute moves: 3 bytes, 8 clocks
// - Status word loads set zero, half-carry, carry
// - Pair-indirect accumulator moves: 1 byte, 6 clocks
// - HL plus displacement moves: 2 bytes, 6 clocks
// - Exchange A with register/short/special: 2 bytes, 6 clocks
`ifndef DTID_MAP_SVH
`define DTID_MAP_SVH

// Address windows
`define DTID_SADDR_BASE   16'hFE20
`define DTID_SFR_BASE     16'hFF00
`define DTID_TABLE_BASE   16'h0040

// Status word reset value and flag positions
`define DTID_STAT_RESET   8'h02
`define DTID_ZERO_BIT     6
`define DTID_HALF_BIT     4
`define DTID_CARRY_BIT    0

// Register indices
`define DTID_IDX_X        3'h0
`define DTID_IDX_A        3'h1
`define DTID_PAIR_DE      2'h2
`define DTID_PAIR_HL      2'h3

// Encoding lengths and clock counts
`define DTID_LEN1         2'h1
`define DTID_LEN2         2'h2
`define DTID_LEN3         2'h3
`define DTID_CLK_SHORT    4'h4
`define DTID_CLK_MID      4'h6
`define DTID_CLK_LONG     4'h8

// Operation codes, upper five bits of the first instruction byte
`define DTID_OP_R_IMM     5'h00
`define DTID_OP_SA_IMM    5'h01
`define DTID_OP_SF_IMM    5'h02
`define DTID_OP_A_R       5'h03
`define DTID_OP_R_A       5'h04
`define DTID_OP_A_SA      5'h05
`define DTID_OP_SA_A      5'h06
`define DTID_OP_A_SF      5'h07
`define DTID_OP_SF_A      5'h08
`define DTID_OP_A_AB      5'h09
`define DTID_OP_AB_A      5'h0A
`define DTID_OP_STAT_IMM  5'h0B
`define DTID_OP_A_STAT    5'h0C
`define DTID_OP_STAT_A    5'h0D
`define DTID_OP_A_DE      5'h0E
`define DTID_OP_DE_A      5'h0F
`define DTID_OP_A_HL      5'h10
`define DTID_OP_HL_A      5'h11
`define DTID_OP_A_HLD     5'h12
`define DTID_OP_HLD_A     5'h13
`define DTID_OP_XA_X      5'h14
`define DTID_OP_XA_R      5'h15
`define DTID_OP_XA_SA     5'h16
`define DTID_OP_XA_SF     5'h17
`define DTID_OP_XA_DE     5'h18
`define DTID_OP_XA_HL     5'h19
`define DTID_OP_XA_HLD    5'h1A

`endif

/* src/dtid_pkg.sv */
// Types and decode helpers for the data-transfer instruction executor
`include "dtid_map.svh"

package dtid_pkg;

    // Immediate operand widths
    typedef logic [15:0] dtid_imm_word_t;
    typedef logic [7:0]  dtid_imm_byte_t;
    typedef logic [2:0]  dtid_imm_bit_t;

    // Operand address forms
    typedef enum logic [2:0] {
        AM_NONE, AM_SADDR, AM_SFR, AM_ABS, AM_DE, AM_HL, AM_HLD
    } dtid_amode_t;

    // Decoded instruction attributes
    typedef struct packed {
        logic [1:0]  len;    // Encoding bytes
        logic [3:0]  clocks; // Total clocks
        dtid_amode_t amode;  // Memory address form
        logic        mem_rd; // Reads memory operand
        logic        mem_wr; // Writes memory operand
        logic        exchange_op;    // Exchange form
    } dtid_dec_t;

    // Instruction byte stream from program memory
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } dtid_fetch_t;

    // Data memory request; read data answers in the same cycle
    typedef struct packed {
        logic        re;
        logic        we;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } dtid_mem_req_t;

    // Short direct offset always lands inside FE20H..FF1FH
    function automatic logic [15:0] dtid_saddr(input logic [7:0] off);
        return `DTID_SADDR_BASE + {8'h00, off};
    endfunction

    // Word short direct or absolute address forced even
    function automatic logic [15:0] dtid_word_addr(input logic [15:0] a);
        return {a[15:1], 1'b0};
    endfunction

    // Table slot: even address inside 0040H..007FH
    function automatic logic [15:0] dtid_table_addr(input logic [4:0] idx);
        return `DTID_TABLE_BASE + {10'h000, idx, 1'b0};
    endfunction

    // Builds one decode entry
    function automatic dtid_dec_t dtid_mk(input logic [1:0] l, input logic [3:0] c,
                                          input dtid_amode_t m, input logic r,
                                          input logic w, input logic x);
        dtid_dec_t d;
        d.len    = l;
        d.clocks = c;
        d.amode  = m;
        d.mem_rd = r;
        d.mem_wr = w;
        d.exchange_op    = x;
        return d;
    endfunction

    // Length, clocks and operand form of each operation
    function automatic dtid_dec_t dtid_decode(input logic [4:0] op);
        dtid_dec_t d;
        d = dtid_mk(`DTID_LEN1, `DTID_CLK_SHORT, AM_NONE, 1'b0, 1'b0, 1'b0);
        case (op)
            `DTID_OP_R_IMM:   d = dtid_mk(`DTID_LEN3, `DTID_CLK_MID, AM_NONE, 1'b0, 1'b0, 1'b0);
            `DTID_OP_SA_IMM:  d = dtid_mk(`DTID_LEN3, `DTID_CLK_MID, AM_SADDR, 1'b0, 1'b1, 1'b0);
            `DTID_OP_SF_IMM:  d = dtid_mk(`DTID_LEN3, `DTID_CLK_MID, AM_SFR, 1'b0, 1'b1, 1'b0);
            `DTID_OP_A_R,
            `DTID_OP_R_A,
            `DTID_OP_A_STAT,
            `DTID_OP_STAT_A:  d = dtid_mk(`DTID_LEN2, `DTID_CLK_SHORT, AM_NONE, 1'b0, 1'b0, 1'b0);
            `DTID_OP_A_SA:    d = dtid_mk(`DTID_LEN2, `DTID_CLK_SHORT, AM_SADDR, 1'b1, 1'b0, 1'b0);
            `DTID_OP_SA_A:    d = dtid_mk(`DTID_LEN2, `DTID_CLK_SHORT, AM_SADDR, 1'b0, 1'b1, 1'b0);
            `DTID_OP_A_SF:    d = dtid_mk(`DTID_LEN2, `DTID_CLK_SHORT, AM_SFR, 1'b1, 1'b0, 1'b0);
            `DTID_OP_SF_A:    d = dtid_mk(`DTID_LEN2, `DTID_CLK_SHORT, AM_SFR, 1'b0, 1'b1, 1'b0);
            `DTID_OP_A_AB:    d = dtid_mk(`DTID_LEN3, `DTID_CLK_LONG, AM_ABS, 1'b1, 1'b0, 1'b0);
            `DTID_OP_AB_A:    d = dtid_mk(`DTID_LEN3, `DTID_CLK_LONG, AM_ABS, 1'b0, 1'b1, 1'b0);
            `DTID_OP_STAT_IMM: d = dtid_mk(`DTID_LEN3, `DTID_CLK_MID, AM_NONE, 1'b0, 1'b0, 1'b0);
            `DTID_OP_A_DE:    d = dtid_mk(`DTID_LEN1, `DTID_CLK_MID, AM_DE, 1'b1, 1'b0, 1'b0);
            `DTID_OP_DE_A:    d = dtid_mk(`DTID_LEN1, `DTID_CLK_MID, AM_DE, 1'b0, 1'b1, 1'b0);
            `DTID_OP_A_HL:    d = dtid_mk(`DTID_LEN1, `DTID_CLK_MID, AM_HL, 1'b1, 1'b0, 1'b0);
            `DTID_OP_HL_A:    d = dtid_mk(`DTID_LEN1, `DTID_CLK_MID, AM_HL, 1'b0, 1'b1, 1'b0);
            `DTID_OP_A_HLD:   d = dtid_mk(`DTID_LEN2, `DTID_CLK_MID, AM_HLD, 1'b1, 1'b0, 1'b0);
            `DTID_OP_HLD_A:   d = dtid_mk(`DTID_LEN2, `DTID_CLK_MID, AM_HLD, 1'b0, 1'b1, 1'b0);
            `DTID_OP_XA_X:    d = dtid_mk(`DTID_LEN1, `DTID_CLK_SHORT, AM_NONE, 1'b0, 1'b0, 1'b1);
            `DTID_OP_XA_R:    d = dtid_mk(`DTID_LEN2, `DTID_CLK_MID, AM_NONE, 1'b0, 1'b0, 1'b1);
            `DTID_OP_XA_SA:   d = dtid_mk(`DTID_LEN2, `DTID_CLK_MID, AM_SADDR, 1'b1, 1'b1, 1'b1);
            `DTID_OP_XA_SF:   d = dtid_mk(`DTID_LEN2, `DTID_CLK_MID, AM_SFR, 1'b1, 1'b1, 1'b1);
            `DTID_OP_XA_DE:   d = dtid_mk(`DTID_LEN1, `DTID_CLK_LONG, AM_DE, 1'b1, 1'b1, 1'b1);
            `DTID_OP_XA_HL:   d = dtid_mk(`DTID_LEN1, `DTID_CLK_LONG, AM_HL, 1'b1, 1'b1, 1'b1);
            `DTID_OP_XA_HLD:  d = dtid_mk(`DTID_LEN2, `DTID_CLK_LONG, AM_HLD, 1'b1, 1'b1, 1'b1);
            default:          d = dtid_mk(`DTID_LEN1, `DTID_CLK_SHORT, AM_NONE, 1'b0, 1'b0, 1'b0);
        endcase
        return d;
    endfunction

endpackage

/* src/dtid_regfile.sv */
// General register file: eight byte registers with byte and pair read ports
`timescale 1ns/1ps
`include "dtid_map.svh"

module dtid_regfile (
    input  wire logic        sys_clk,  // Core clock
    input  wire logic        rst_n,    // Synchronous reset, active low
    input  wire logic [2:0]  rd_idx,   // Byte read index
    input  wire logic [1:0]  pair_sel, // Pair read index
    input  wire logic        wa_en,    // Write port A enable
    input  wire logic [2:0]  wa_idx,   // Write port A index
    input  wire logic [7:0]  wa_data,  // Write port A data
    input  wire logic        wb_en,    // Write port B enable
    input  wire logic [2:0]  wb_idx,   // Write port B index
    input  wire logic [7:0]  wb_data,  // Write port B data
    output logic      [7:0]  rd_data,  // Byte read data, registered
    output logic      [15:0] pair_data, // Pair read data, registered
    output logic      [15:0] acc_word  // A as high byte, X as low byte
);
    import dtid_pkg::*;

    logic [7:0] regs [8];      // X,A,C,B,E,D,L,H at indices 0..7
    logic [7:0] next_regs [8]; // Next register values

    // Per-register write select; port A wins over port B
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_reg
            always_comb begin
                next_regs[gi] = regs[gi];
                if (wb_en && wb_idx == 3'(gi)) begin
                    next_regs[gi] = wb_data;
                end
                if (wa_en && wa_idx == 3'(gi)) begin
                    next_regs[gi] = wa_data;
                end
            end
            always_ff @(posedge sys_clk) begin
                if (!rst_n) begin
                    regs[gi] <= 8'h00;
                end else begin
                    regs[gi] <= next_regs[gi];
                end
            end
        end
    endgenerate

    // Registered reads; a pair is its odd register above its even one
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rd_data <= 8'h00;
            pair_data <= 16'h0000;
        end else begin
            rd_data <= regs[rd_idx];
            pair_data <= {regs[{pair_sel, 1'b1}], regs[{pair_sel, 1'b0}]};
        end
    end

    // Word accumulator straight from the A and X flops
    assign acc_word = {regs[`DTID_IDX_A], regs[`DTID_IDX_X]};

endmodule

/* src/dtid_core.sv */
// Data-transfer and exchange instruction executor with its register file
`timescale 1ns/1ps
`include "dtid_map.svh"

module dtid_core (
    input  wire logic                  sys_clk,     // Core clock, 125 MHz
    input  wire logic                  rst_n,       // Synchronous reset, active low
    input  wire dtid_pkg::dtid_fetch_t fetch,       // Instruction byte stream
    output logic                       fetch_ready, // Byte taken when valid and ready
    output dtid_pkg::dtid_mem_req_t    mem_req,     // Data memory request, registered
    input  wire logic [7:0]            mem_rdata,   // Read data, same cycle as request
    output logic [7:0]                 status_word, // Flags register
    output logic [15:0]                word_acc,    // Word accumulator A:X
    output logic                       irq_hold,    // High while an instruction runs
    output logic                       instr_done   // Pulse in the clock after the last
);
    import dtid_pkg::*;

    // Sequencer states
    typedef enum logic [1:0] {ST_FETCH, ST_OPER, ST_EXEC} dtid_state_t;

    dtid_state_t   state;           // Current state
    dtid_state_t   next_state;      // Next state
    logic [3:0]    cyc;             // Clock index inside the instruction
    logic [3:0]    next_cyc;
    logic [4:0]    op;              // Latched operation
    logic [4:0]    next_op;
    logic [2:0]    rf;              // Latched register field
    logic [2:0]    next_rf;
    logic [7:0]    b1;              // Second instruction byte
    logic [7:0]    next_b1;
    logic [7:0]    b2;              // Third instruction byte
    logic [7:0]    next_b2;
    logic [7:0]    next_status_word;
    logic          next_instr_done;
    dtid_mem_req_t next_mem_req;

    logic [4:0]    cur_op;          // Operation seen this cycle
    dtid_dec_t     dec;             // Its decode
    logic          take;            // Byte accepted this cycle
    logic [3:0]    len4;            // Length widened for compares
    logic          at_issue;        // First execute clock
    logic          at_commit;       // Second execute clock
    logic [15:0]   eff_addr;        // Memory operand address
    logic [7:0]    acc;             // Accumulator A
    logic [2:0]    rd_idx;          // Register read index
    logic [1:0]    pair_sel;        // Pair read index
    logic [7:0]    rd_data;         // Registered register read
    logic [15:0]   pair_data;       // Registered pair read
    logic          wa_en;           // Accumulator write
    logic [7:0]    wa_data;
    logic          wb_en;           // Other register write
    logic [7:0]    wb_data;

    // Operation fields come straight from the byte while waiting for an opcode
    always_comb begin
        cur_op    = (state == ST_FETCH) ? fetch.data[7:3] : op;
        dec       = dtid_decode(cur_op);
        len4      = {2'b00, dec.len};
        take      = fetch.valid && fetch_ready;
        at_issue  = (state == ST_EXEC) && (cyc == len4);
        at_commit = (state == ST_EXEC) && (cyc == len4 + 4'h1);
        acc       = word_acc[15:8];
    end

    // Bytes are taken only outside execution
    assign fetch_ready = (state != ST_EXEC);
    // Nothing may interrupt between the read and the write halves
    assign irq_hold    = (state != ST_FETCH);

    // Read port selection; exchange with X always reads index 0
    always_comb begin
        rd_idx = (state == ST_FETCH) ? fetch.data[2:0] : rf;
        if (cur_op == `DTID_OP_XA_X) begin
            rd_idx = `DTID_IDX_X;
        end
        pair_sel = (dec.amode == AM_DE) ? `DTID_PAIR_DE : `DTID_PAIR_HL;
    end

    // Operand address by form
    always_comb begin
        unique case (dec.amode)
            AM_SADDR: eff_addr = dtid_saddr(b1);
            AM_SFR:   eff_addr = `DTID_SFR_BASE + {8'h00, b1};
            AM_ABS:   eff_addr = {b2, b1};
            AM_DE:    eff_addr = pair_data;
            AM_HL:    eff_addr = pair_data;
            AM_HLD:   eff_addr = pair_data + {8'h00, b1};
            default:  eff_addr = 16'h0000;
        endcase
    end

    // Sequencer: opcode, operand bytes, then execute up to the clock count
    always_comb begin
        next_state      = state;
        next_cyc        = cyc;
        next_op         = op;
        next_rf         = rf;
        next_b1         = b1;
        next_b2         = b2;
        next_instr_done = 1'b0;
        unique case (state)
            ST_FETCH: begin
                if (take) begin
                    next_op    = fetch.data[7:3];
                    next_rf    = fetch.data[2:0];
                    next_cyc   = 4'h1;
                    // Single-byte forms go straight to execution
                    next_state = (dec.len == `DTID_LEN1) ? ST_EXEC : ST_OPER;
                end
            end
            ST_OPER: begin
                if (take) begin
                    // Second byte then third byte
                    if (cyc == 4'h1) begin
                        next_b1 = fetch.data;
                    end else begin
                        next_b2 = fetch.data;
                    end
                    next_cyc = cyc + 4'h1;
                    if (cyc == len4 - 4'h1) begin
                        next_state = ST_EXEC;
                    end
                end
            end
            ST_EXEC: begin
                next_cyc = cyc + 4'h1;
                // Finish exactly at the documented clock count
                if (cyc == dec.clocks - 4'h1) begin
                    next_state      = ST_FETCH;
                    next_instr_done = 1'b1;
                    next_cyc        = 4'h0;
                end
            end
        endcase
    end

    // Memory requests: read or store at issue, exchange write-back at commit
    always_comb begin
        next_mem_req = '0;
        if (at_issue && dec.mem_rd) begin
            next_mem_req.re   = 1'b1;
            next_mem_req.addr = eff_addr;
        end else if (at_issue && dec.mem_wr && !dec.exchange_op) begin
            next_mem_req.we    = 1'b1;
            next_mem_req.addr  = eff_addr;
            // Immediate stores carry the third byte; absolute and other stores carry A
            next_mem_req.wdata = (dec.len == `DTID_LEN3 && dec.amode != AM_ABS) ?
                                 b2 : acc;
        end else if (at_commit && dec.mem_wr && dec.exchange_op) begin
            // Old accumulator goes back to the operand inside the same instruction
            next_mem_req.we    = 1'b1;
            next_mem_req.addr  = eff_addr;
            next_mem_req.wdata = acc;
        end
    end

    // Register and flag writes in the commit clock
    always_comb begin
        wa_en            = 1'b0;
        wa_data          = 8'h00;
        wb_en            = 1'b0;
        wb_data          = 8'h00;
        next_status_word = status_word;
        if (at_commit) begin
            unique case (op)
                `DTID_OP_R_IMM: begin
                    wb_en   = 1'b1;
                    wb_data = b2;
                end
                `DTID_OP_R_A: begin
                    wb_en   = 1'b1;
                    wb_data = acc;
                end
                `DTID_OP_A_R: begin
                    wa_en   = 1'b1;
                    wa_data = rd_data;
                end
                `DTID_OP_A_SA, `DTID_OP_A_SF, `DTID_OP_A_AB, `DTID_OP_A_DE,
                `DTID_OP_A_HL, `DTID_OP_A_HLD: begin
                    wa_en   = 1'b1;
                    wa_data = mem_rdata;
                end
                `DTID_OP_A_STAT: begin
                    wa_en   = 1'b1;
                    wa_data = status_word;
                end
                `DTID_OP_STAT_IMM: begin
                    next_status_word = b2;
                end
                `DTID_OP_STAT_A: begin
                    next_status_word = acc;
                end
                `DTID_OP_XA_X, `DTID_OP_XA_R: begin
                    // Both halves land on the same edge
                    wa_en   = 1'b1;
                    wa_data = rd_data;
                    wb_en   = 1'b1;
                    wb_data = acc;
                end
                `DTID_OP_XA_SA, `DTID_OP_XA_SF, `DTID_OP_XA_DE, `DTID_OP_XA_HL,
                `DTID_OP_XA_HLD: begin
                    wa_en   = 1'b1;
                    wa_data = mem_rdata;
                end
                default: begin
                    // Stores and unknown codes touch no register
                    wa_en = 1'b0;
                end
            endcase
        end
    end

    // State registers
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state       <= ST_FETCH;
            cyc         <= 4'h0;
            op          <= 5'h00;
            rf          <= 3'h0;
            b1          <= 8'h00;
            b2          <= 8'h00;
            status_word <= `DTID_STAT_RESET;
            mem_req     <= '0;
            instr_done  <= 1'b0;
        end else begin
            state       <= next_state;
            cyc         <= next_cyc;
            op          <= next_op;
            rf          <= next_rf;
            b1          <= next_b1;
            b2          <= next_b2;
            status_word <= next_status_word;
            mem_req     <= next_mem_req;
            instr_done  <= next_instr_done;
        end
    end

    // Register file; port B targets the latched field, or X for the short exchange
    dtid_regfile u_regs (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .rd_idx   (rd_idx),
        .pair_sel (pair_sel),
        .wa_en    (wa_en),
        .wa_idx   (`DTID_IDX_A),
        .wa_data  (wa_data),
        .wb_en    (wb_en),
        .wb_idx   ((op == `DTID_OP_XA_X) ? `DTID_IDX_X : rf),
        .wb_data  (wb_data),
        .rd_data  (rd_data),
        .pair_data(pair_data),
        .acc_word (word_acc)
    );

endmodule

/* test/dtid_core_assertions.sv */
// Port-level timing checks for the data-transfer executor
`timescale 1ns/1ps
module dtid_core_assertions import dtid_pkg::*; (
    input wire logic                    sys_clk,     // Core clock
    input wire logic                    rst_n,       // Synchronous reset, active low
    input wire dtid_pkg::dtid_fetch_t   fetch,       // Instruction bytes
    input wire logic                    fetch_ready, // Byte accepted
    input wire dtid_pkg::dtid_mem_req_t mem_req,     // Data memory request
    input wire logic [7:0]              mem_rdata,   // Read data
    input wire logic [7:0]              status_word, // Flags
    input wire logic [15:0]             word_acc,    // A:X
    input wire logic                    irq_hold,    // Instruction running
    input wire logic                    instr_done   // Pulse after the last clock
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    logic       take; // Opcode byte accepted
    logic [4:0] op;   // Operation field of the offered byte
    assign take = fetch.valid && fetch_ready && (!irq_hold || instr_done);
    assign op   = fetch.data[7:3];
    a_done_pulse: assert property (instr_done |=> !instr_done)
        else $error("done pulse held");
    a_done_ends: assert property (instr_done |-> $past(irq_hold))
        else $error("done without running instruction");
    a_strobe_excl: assert property (!(mem_req.re && mem_req.we))
        else $error("read and write together");
    a_addr_idle: assert property (!(mem_req.re || mem_req.we) |->
        mem_req.addr == 16'h0000 && mem_req.wdata == 8'h00) else $error("bus not idle");
    a_read_busy: assert property (mem_req.re |-> irq_hold && !instr_done)
        else $error("read outside instruction");
    a_short_clocks: assert property (take && op inside {5'h03, 5'h04, 5'h05, 5'h06,
        5'h07, 5'h08, 5'h0C, 5'h0D, 5'h14} |-> ##4 instr_done) else $error("short count");
    a_mid_clocks: assert property (take && op inside {5'h00, 5'h01, 5'h02, 5'h0B,
        [5'h0E:5'h13], [5'h15:5'h17]} |-> ##6 instr_done) else $error("mid count");
    a_long_clocks: assert property (take && op inside {5'h09, 5'h0A,
        [5'h18:5'h1A]} |-> ##8 instr_done) else $error("long count");
    a_flags_quiet: assert property ($past(rst_n) && !$stable(status_word) |->
        $past(irq_hold)) else $error("flags changed while idle");
    a_acc_quiet: assert property ($past(rst_n) && !$stable(word_acc) |->
        $past(irq_hold)) else $error("accumulator changed while idle");
endmodule

bind dtid_core dtid_core_assertions dtid_core_assertions_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .fetch(fetch), .fetch_ready(fetch_ready), .mem_req(mem_req), .mem_rdata(mem_rdata),
    .status_word(status_word), .word_acc(word_acc), .irq_hold(irq_hold),
    .instr_done(instr_done));

/* test/dtid_mem_model.sv */
// Data memory model answering reads in the same cycle
`timescale 1ns/1ps
module dtid_mem_model import dtid_pkg::*; (
    input wire logic                    sys_clk,  // Core clock
    input wire dtid_pkg::dtid_mem_req_t mem_req,  // Request from the core
    output logic [7:0]                  mem_rdata // Read answer
);
    logic [7:0] mem [0:65535];    // Byte storage
    logic [7:0] idle_pat = 8'h5A; // Changing value when not read
    // Write at the edge ending the strobe cycle; idle pattern flips each cycle
    always @(posedge sys_clk) begin
        idle_pat <= ~idle_pat;
        if (mem_req.we) mem[mem_req.addr] <= mem_req.wdata;
    end
    // Undriven read data shows a changing pattern, never the last value
    assign mem_rdata = mem_req.re ? mem[mem_req.addr] : idle_pat;
endmodule

/* test/dtid_core_tb.sv */
// Self-checking bench for the data-transfer executor
`timescale 1ns/1ps
module dtid_core_tb;
    import dtid_pkg::*;
    // One instruction: bytes, length, clocks, expected A:X and flags
    typedef struct packed {
        logic [7:0]  b0, b1, b2;
        logic [1:0]  len;
        logic [3:0]  clk;
        logic [15:0] acc;
        logic [7:0]  flags;
    } dtid_row_t;
    logic          sys_clk = 1'b0; // Core clock
    logic          rst_n = 1'b0;   // Reset, active low
    dtid_fetch_t   fetch = '0;     // Instruction bytes
    logic          fetch_ready, irq_hold, instr_done;
    dtid_mem_req_t mem_req;
    logic [7:0]    mem_rdata, status_word;
    logic [15:0]   word_acc;
    int            bad_count = 0, checks_done = 0;
    dtid_row_t     rows [13] = '{
        '{8'h01, 8'h00, 8'h5A, 2'h3, 4'h6, 16'h5A00, 8'h02}, '{8'hA0, 8'h00, 8'h00, 2'h1, 4'h4,
        16'h005A, 8'h02}, '{8'h28, 8'h10, 8'h00, 2'h2, 4'h4, 16'h3C5A, 8'h02}, '{8'h50, 8'h34,
        8'h12, 2'h3, 4'h8, 16'h3C5A, 8'h02}, '{8'h68, 8'h00, 8'h00, 2'h2, 4'h4, 16'h3C5A, 8'h3C},
        '{8'h58, 8'h00, 8'h51, 2'h3, 4'h6, 16'h3C5A, 8'h51}, '{8'h27, 8'h00, 8'h00, 2'h2, 4'h4,
        16'h3C5A, 8'h51}, '{8'h26, 8'h00, 8'h00, 2'h2, 4'h4, 16'h3C5A, 8'h51}, '{8'hD0, 8'h04,
        8'h00, 2'h2, 4'h8, 16'h995A, 8'h51}, '{8'h70, 8'h00, 8'h00, 2'h1, 4'h6, 16'h775A, 8'h51},
        '{8'hB8, 8'h05, 8'h00, 2'h2, 4'h6, 16'h115A, 8'h51}, '{8'h60, 8'h00, 8'h00, 2'h2, 4'h4,
        16'h515A, 8'h51}, '{8'hF8, 8'h00, 8'h00, 2'h1, 4'h4, 16'h515A, 8'h51}};

    dtid_core dtid_core_i (.sys_clk(sys_clk), .rst_n(rst_n), .fetch(fetch),
        .fetch_ready(fetch_ready), .mem_req(mem_req), .mem_rdata(mem_rdata),
        .status_word(status_word), .word_acc(word_acc), .irq_hold(irq_hold),
        .instr_done(instr_done));
    dtid_mem_model dtid_mem_model_i (.sys_clk(sys_clk), .mem_req(mem_req),
        .mem_rdata(mem_rdata));

    // Free-running 125 MHz clock
    initial begin
        forever #4 sys_clk = ~sys_clk;
    end

    // Compares one value and counts it
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %0t got %h want %h", $time, got, exp);
        end
    endtask

    // Prints the verdict and ends the run
    task automatic final_report();
        if (bad_count == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Feeds one instruction back to back and counts clocks to completion
    task automatic run(input dtid_row_t r);
        int n;
        fetch = {1'b1, r.b0};
        for (n = 1; n < 12; n++) begin
            @(negedge sys_clk);
            if (instr_done === 1'b1) break;
            fetch = {n < r.len, (n == 1) ? r.b1 : r.b2};
        end
        chk(16'(n), {12'h000, r.clk});
        chk(word_acc, r.acc);
        chk({8'h00, status_word}, {8'h00, r.flags});
    endtask

    // Main sequence: reset, table of instructions, memory effects, closing reset while idle
    initial begin
        dtid_mem_model_i.mem[16'hFE30] = 8'h3C;
        dtid_mem_model_i.mem[16'h3C40] = 8'h99;
        dtid_mem_model_i.mem[16'h0000] = 8'h77;
        dtid_mem_model_i.mem[16'hFF05] = 8'h11;
        repeat (2) @(negedge sys_clk);
        rst_n = 1'b1;
        chk(word_acc, 16'h0000);
        chk({8'h00, status_word}, 16'h0002);
        foreach (rows[i]) run(rows[i]);
        chk({8'h00, dtid_mem_model_i.mem[16'h1234]}, 16'h003C);
        chk({8'h00, dtid_mem_model_i.mem[16'h3C40]}, 16'h003C);
        chk({8'h00, dtid_mem_model_i.mem[16'hFF05]}, 16'h0077);
        chk(dtid_table_addr(5'h1F), 16'h007E);
        chk(dtid_saddr(8'hFF), 16'hFF1F);
        rst_n = 1'b0;
        @(negedge sys_clk);
        rst_n = 1'b1;
        chk(word_acc, 16'h0000);
        chk({8'h00, status_word}, 16'h0002);
        final_report();
    end

    // Watchdog cuts a hang short
    initial begin
        #5000;
        bad_count++;
        final_report();
    end
endmodule
